// [logic/slave_port_defines.vh]
// Constants for the register slave access port.
// Summary of operation
// - Latch address and direction at strobe release.
// - Chip select and strobe synchronized internally.
// - Ready mode: acknowledge within zero to four cycles.
// - Idle gives shortest latency, busy gives longest.
// - Missed strobe sample: acknowledge only after release.
// - Each strobe pulse is a separate cycle.
// - Ready low on edge, high on release.
// - Acknowledge rises immediately on strobe or select release.
// - Early select release times all releases except the size-ack float.
// - Port-size mode: acknowledge one to four cycles.
// - Master wait states lengthen acknowledge latency.
// - Held select: strobe ends and restarts cycles.
// - Held select: acknowledge once strobe sampled.
// - Both size acks low together, float later.
// - Read data launched from a clock edge.
// - Data bus floats after strobe release.
// - Write data captured on a clock edge.
// - Only strobe release floats size acks.
// - Acknowledge lasts only while strobe active.
`ifndef SLAVE_PORT_DEFINES_VH
`define SLAVE_PORT_DEFINES_VH
`define ADDR_W          6
`define DATA_W          16
`define SYNC_STAGES     2
`define IDLE_WAIT       3'h0
`define BUSY_WAIT_READY 3'h4
`define BUSY_WAIT_SIZE  3'h4
`define SIZE_MIN_WAIT   3'h1
`endif

// [logic/async_sync.v]
// Multi-stage synchronizer for one asynchronous active-low level.
`timescale 1ns/100ps
`include "slave_port_defines.vh"
module async_sync (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire din_n,
  output wire dout_n
);
  reg [`SYNC_STAGES-1:0] stage;
  always @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= {`SYNC_STAGES{1'b1}};
    end else begin
      stage <= {stage[`SYNC_STAGES-2:0], din_n};
    end
  end
  assign dout_n = stage[`SYNC_STAGES-1];
endmodule

// [logic/latency_timer.v]
// Down counter that holds off the acknowledge for a set number of cycles.
`timescale 1ns/100ps
`include "slave_port_defines.vh"
module latency_timer (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       load,
  input  wire [2:0] load_value,
  input  wire       stall,
  output wire       done
);
  reg [2:0] count;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 3'h0;
    end else if (load) begin
      count <= load_value;
    end else if (!stall && count != 3'h0) begin
      count <= count - 3'h1;
    end
  end
  // A stall also holds back a zero count, so wait states always add latency.
  assign done = (count == 3'h0) && !load && !stall;
endmodule

// [logic/register_slave_access.v]
// Slave register access port: select, strobe, acknowledges and data bus.
`timescale 1ns/100ps
`include "slave_port_defines.vh"
module register_slave_access (
  input  wire               ref_clk,
  input  wire               rst_n,
  input  wire               bus_style_select,
  input  wire               chip_select_n,
  input  wire               slave_address_strobe_n,
  input  wire               slave_write_not_read,
  input  wire [`ADDR_W-1:0] reg_addr,
  input  wire [`DATA_W-1:0] data_in,
  output wire [`DATA_W-1:0] data_out,
  output wire               data_oe_n,
  input  wire               device_busy,
  input  wire               master_wait,
  output wire               slave_access_ack_n,
  output wire               ready_out_n,
  output wire               port_size_ack_n,
  output wire               port_size_ack_oe_n,
  output reg  [`ADDR_W-1:0] reg_index,
  output reg                slave_read_write,
  output reg                wr_strobe,
  output reg  [`DATA_W-1:0] wr_data,
  output reg                rd_strobe,
  input  wire [`DATA_W-1:0] rd_data
);
  // Slave cycle states.
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_ACK  = 2'h2;
  localparam ST_DONE = 2'h3;

  wire cs_sync_n;
  wire sas_sync_n;
  wire timer_done;
  reg  [1:0] state;
  reg  [1:0] next_state;
  reg        ack_q;
  reg        size_float;
  reg        sas_prev_n;
  reg        missed;
  reg        cs_prev_n;
  reg  [`DATA_W-1:0] rd_q;
  reg        rd_drive;
  reg        load;
  reg  [2:0] load_value;

  async_sync u_cs_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din_n   (chip_select_n),
    .dout_n  (cs_sync_n)
  );

  async_sync u_sas_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din_n   (slave_address_strobe_n),
    .dout_n  (sas_sync_n)
  );

  latency_timer u_timer (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .load       (load),
    .load_value (load_value),
    .stall      (master_wait),
    .done       (timer_done)
  );

  // Strobe is active low in ready mode and high in port-size mode.
  function strobe_on;
    input style;
    input sas_n;
    begin
      strobe_on = style ? sas_n : !sas_n;
    end
  endfunction

  // Acknowledge hold-off for the bus style and the activity of the device.
  // A busy device gets the long figure so that a register access never
  // races the work that is already under way.
  function [2:0] wait_cycles;
    input style;
    input busy;
    begin
      if (style) begin
        wait_cycles = busy ? `BUSY_WAIT_SIZE : `SIZE_MIN_WAIT;
      end else begin
        wait_cycles = busy ? `BUSY_WAIT_READY : `IDLE_WAIT;
      end
    end
  endfunction

  // The live terms use the raw pins, so releases do not wait for a clock.
  wire sas_live     = strobe_on(bus_style_select, slave_address_strobe_n);
  wire sas_seen     = strobe_on(bus_style_select, sas_sync_n);
  wire sas_was_seen = strobe_on(bus_style_select, sas_prev_n);
  wire access       = !cs_sync_n && sas_seen;
  wire live         = !chip_select_n && sas_live;
  // First cycle in which the synchronized select is seen active.
  wire cs_first     = cs_prev_n && !cs_sync_n;
  // One-cycle term for the edge that enters the acknowledge.
  wire take         = (state == ST_WAIT) && (next_state == ST_ACK);
  wire take_rd      = take && !slave_write_not_read;
  wire take_wr      = take && slave_write_not_read;

  always @* begin
    next_state = state;
    load       = 1'b0;
    load_value = `IDLE_WAIT;
    case (state)
      ST_IDLE: begin
        if (access && !missed) begin
          load = 1'b1;
          load_value = wait_cycles(bus_style_select, device_busy);
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!access) begin
          next_state = ST_DONE;
        end else if (timer_done) begin
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!access) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!sas_seen) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Synchronized strobe, one cycle back, for its release edge.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sas_prev_n <= 1'b1;
    end else begin
      sas_prev_n <= sas_sync_n;
    end
  end

  // Synchronized select, one cycle back, for its first active cycle.
  // Only the second synchronizer stage is read here, never the first.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_n <= 1'b1;
    end else begin
      cs_prev_n <= cs_sync_n;
    end
  end

  // Slave cycle state.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // late strobe held off
  // A select seen ahead of its strobe marks the access as missed. The mark
  // outranks a clear in the same cycle and holds until that strobe has been
  // seen and dropped again, or until the select goes away.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      missed <= 1'b0;
    end else if (state == ST_IDLE && cs_first && !sas_seen) begin
      missed <= 1'b1;
    end else if (cs_sync_n || (sas_was_seen && !sas_seen)) begin
      missed <= 1'b0;
    end
  end

  // ready on clock edge
  // Registered so that the acknowledge is launched from a clock edge; only
  // its release is combinational.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (next_state == ST_ACK);
    end
  end

  // float only on strobe
  // A select release only drops the size acknowledge. The lines are floated
  // once the strobe release is seen, so another agent can take them over.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      size_float <= 1'b1;
    end else if (next_state == ST_ACK) begin
      size_float <= 1'b0;
    end else if (!sas_seen) begin
      size_float <= 1'b1;
    end
  end

  // select release also ends
  // The release is combinational on purpose: it must not wait for a clock.
  assign slave_access_ack_n = !(ack_q && live);
  assign ready_out_n = !(ack_q && live && !bus_style_select);
  assign port_size_ack_n = !(ack_q && live && bus_style_select);
  assign port_size_ack_oe_n = !(bus_style_select && !size_float);

  // latch on strobe release
  // The address is taken while the select is still seen, so a strobe that
  // ends together with the select still leaves its address behind.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_index <= {`ADDR_W{1'b0}};
    end else if (access && !sas_live) begin
      reg_index <= reg_addr;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_read_write <= 1'b0;
    end else if (access && !sas_live) begin
      slave_read_write <= slave_write_not_read;
    end
  end

  // Write pulse toward the register file.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_strobe <= 1'b0;
    end else begin
      wr_strobe <= take_wr;
    end
  end

  // write data on edge
  // The host holds the word from the strobe to the acknowledge, so the edge
  // that enters the acknowledge always finds it settled.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_data <= {`DATA_W{1'b0}};
    end else if (take_wr) begin
      wr_data <= data_in;
    end
  end

  // Read pulse toward the register file.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_strobe <= 1'b0;
    end else begin
      rd_strobe <= take_rd;
    end
  end

  // read data from edge
  // The word is launched on the edge that enters the acknowledge, so it
  // already stands on the bus when the host first sees the acknowledge.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= {`DATA_W{1'b0}};
    end else if (take_rd) begin
      rd_q <= rd_data;
    end
  end

  // The read drive is held from the read edge until the access is no longer seen; a pin release ends the bus drive sooner.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_drive <= 1'b0;
    end else if (take_rd) begin
      rd_drive <= 1'b1;
    end else if (!access) begin
      rd_drive <= 1'b0;
    end
  end

  assign data_out = rd_q;
  assign data_oe_n = !(rd_drive && live && !slave_write_not_read);
endmodule

// [sim/slave_port_check_assertions.sv]
// Concurrent checks on the register slave access port.
`timescale 1ns/100ps
module slave_port_check (
  input wire logic ref_clk, rst_n, bus_style_select, chip_select_n,
  input wire logic slave_address_strobe_n, device_busy, master_wait,
  input wire logic slave_access_ack_n, ready_out_n, port_size_ack_n,
  input wire logic port_size_ack_oe_n, data_oe_n, wr_strobe, rd_strobe,
  input wire logic slave_write_not_read
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // The strobe is active low in ready mode and active high otherwise.
  wire logic on = bus_style_select ~^ slave_address_strobe_n;
  wire logic req = on && !chip_select_n;
  sequence s_go; $rose(on) && !chip_select_n && !master_wait; endsequence
  sequence s_end; $fell(on); endsequence
  property p_live; !slave_access_ack_n |-> req; endproperty
  a_live: assert property (p_live) else $error("ack without access");
  property p_sync;
    s_go |-> slave_access_ack_n ##1 slave_access_ack_n;
  endproperty
  a_sync: assert property (p_sync) else $error("ack before sync");
  property p_bound;
    s_go |-> ##[1:8] (!slave_access_ack_n || !req || master_wait);
  endproperty
  a_bound: assert property (p_bound) else $error("ack late");
  property p_busy;
    s_go ##0 device_busy |-> slave_access_ack_n [*4];
  endproperty
  a_busy: assert property (p_busy) else $error("busy ack early");
  property p_rdy; s_end |-> ##[0:3] ready_out_n; endproperty
  a_rdy: assert property (p_rdy) else $error("ready held");
  property p_pair;
    !port_size_ack_n |-> !port_size_ack_oe_n && bus_style_select;
  endproperty
  a_pair: assert property (p_pair) else $error("size ack undriven");
  property p_float; s_end |-> ##[0:3] port_size_ack_oe_n; endproperty
  a_float: assert property (p_float) else $error("size ack driven");
  property p_dfloat; s_end |-> ##[0:3] data_oe_n; endproperty
  a_dfloat: assert property (p_dfloat) else $error("data still driven");
  property p_wr;
    wr_strobe |-> slave_write_not_read && !chip_select_n;
  endproperty
  a_wr: assert property (p_wr) else $error("bad write pulse");
  property p_rd;
    rd_strobe |-> !slave_write_not_read && !chip_select_n;
  endproperty
  a_rd: assert property (p_rd) else $error("bad read pulse");
endmodule
bind register_slave_access slave_port_check chk (.*);

// [sim/host_model.sv]
// Host processor model that makes register accesses on the slave port.
`timescale 1ns/100ps
`include "slave_port_defines.vh"
module host_model (
  input  wire logic               ref_clk, style, ack_n, oe_n,
  input  wire logic [`DATA_W-1:0] rd_bus,
  output logic                    cs_n = 1'b1,
  output logic                    sas_n = 1'b1,
  output logic                    wnr = 1'b0,
  output logic [`ADDR_W-1:0]      addr = 6'h00,
  output logic [`DATA_W-1:0]      wdata = 16'h0000
);
  task automatic access(input logic w, input logic [`ADDR_W-1:0] a,
      input logic [`DATA_W-1:0] d, input logic keep, output int lat,
      output logic [`DATA_W-1:0] got);
    @(posedge ref_clk);
    if (!keep) cs_n <= 1'b1;
    sas_n <= !style;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    sas_n <= style;
    wnr <= w;
    addr <= a;
    wdata <= d;
    lat = 0;
    do begin
      @(posedge ref_clk);
      lat++;
    end while (ack_n !== 1'b0 && lat < 40);
    got = oe_n ? 'x : rd_bus;
    sas_n <= !style;
    // A released data bus must not look like held data.
    wdata <= ~d;
  endtask
  // Drops the select, lets it clear the synchronizer, then parks the
  // strobe at the idle level of the coming bus style.
  task automatic park(input logic st);
    @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sas_n <= !st;
  endtask
endmodule

// [sim/test_register_slave_access.sv]
// Self-checking testbench for the register slave access port.
`timescale 1ns/100ps
`include "slave_port_defines.vh"
module test_register_slave_access;
  logic ref_clk = 1'b0, rst_n = 1'b0, style = 1'b0, busy = 1'b0, mwait = 1'b0;
  logic [`DATA_W-1:0] rd_data = 16'h0000, got, last_wr = 16'h0000;
  wire cs_n, sas_n, wnr, ack_n, rdy_n, psa_n, psa_oe_n, oe_n, wr_s, rd_s, rw;
  wire [`ADDR_W-1:0] addr, idx;
  wire [`DATA_W-1:0] wdata, dout, wr_data;
  int failures = 0, n_checks = 0, n_wr = 0, lat, lat0;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (wr_s === 1'b1) begin
      last_wr <= wr_data;
      n_wr <= n_wr + 1;
    end
  end
  register_slave_access uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus_style_select(style), .chip_select_n(cs_n),
    .slave_address_strobe_n(sas_n), .slave_write_not_read(wnr),
    .reg_addr(addr), .data_in(wdata), .data_out(dout), .data_oe_n(oe_n),
    .device_busy(busy), .master_wait(mwait), .slave_access_ack_n(ack_n),
    .ready_out_n(rdy_n), .port_size_ack_n(psa_n),
    .port_size_ack_oe_n(psa_oe_n), .reg_index(idx), .slave_read_write(rw),
    .wr_strobe(wr_s), .wr_data(wr_data), .rd_strobe(rd_s),
    .rd_data(rd_data));
  // The size acknowledge is pulled up while undriven.
  host_model host (.ref_clk(ref_clk), .style(style),
    .ack_n(style ? (psa_oe_n | psa_n) : rdy_n), .oe_n(oe_n), .rd_bus(dout),
    .cs_n(cs_n), .sas_n(sas_n), .wnr(wnr), .addr(addr), .wdata(wdata));
  task automatic check(input string what, input logic [15:0] exp, seen);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic go(input logic w, input logic [5:0] a, input logic [15:0] d,
      input logic keep);
    host.access(w, a, d, keep, lat, got);
    #1 check("ack_release", 16'h0001, 16'(ack_n));
  endtask
  task automatic settle(input logic [5:0] a, input logic w);
    repeat (3) @(posedge ref_clk);
    check("reg_index", 16'(a), 16'(idx));
    check("direction", 16'(w), 16'(rw));
  endtask
  task automatic t_write_idle;
    go(1'b1, 6'h2A, 16'hA5C3, 1'b0);
    lat0 = lat;
    check("idle_lat", 16'h0001, 16'(lat <= 4));
    settle(6'h2A, 1'b1);
    check("wr_data", 16'hA5C3, last_wr);
  endtask
  task automatic t_read_busy;
    busy <= 1'b1;
    rd_data <= 16'h3C96;
    go(1'b0, 6'h05, 16'h0000, 1'b0);
    check("rd_data", 16'h3C96, got);
    check("busy_lat", 16'h0001, 16'(lat > lat0 && lat <= lat0 + 4));
    settle(6'h05, 1'b0);
    check("data_float", 16'h0001, 16'(oe_n));
    busy <= 1'b0;
  endtask
  task automatic t_b2b;
    int base;
    base = n_wr;
    go(1'b1, 6'h11, 16'h1234, 1'b0);
    go(1'b1, 6'h12, 16'h5678, 1'b1);
    settle(6'h12, 1'b1);
    check("wr_count", 16'(base + 2), 16'(n_wr));
    check("wr_data", 16'h5678, last_wr);
  endtask
  task automatic t_wait;
    mwait <= 1'b1;
    fork
      begin
        repeat (12) @(posedge ref_clk);
        mwait <= 1'b0;
      end
      go(1'b0, 6'h07, 16'h0000, 1'b0);
    join
    check("wait_lat", 16'h0001, 16'(lat > 9));
    settle(6'h07, 1'b0);
  endtask
  task automatic t_size;
    host.park(1'b1);
    style <= 1'b1;
    rd_data <= 16'hF00D;
    go(1'b0, 6'h3F, 16'h0000, 1'b0);
    check("size_rd", 16'hF00D, got);
    check("size_lat", 16'h0001, 16'(lat > lat0 && lat <= lat0 + 5));
    go(1'b1, 6'h00, 16'h0FF0, 1'b1);
    settle(6'h00, 1'b1);
    check("size_wr", 16'h0FF0, last_wr);
    check("size_float", 16'h0001, 16'(psa_oe_n));
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_write_idle;
    t_read_busy;
    t_b2b;
    t_wait;
    t_size;
    print_verdict;
  end
  // The tests take under a hundred cycles; this cuts off a hang.
  initial begin
    #100us;
    failures++;
    print_verdict;
  end
endmodule
